/* File: logic/sqe_defs.vh */
// Constants for the SCSI host request queue engine
`ifndef SQE_DEFS_VH
`define SQE_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define SQE_OFS_QCNT 8'h00
`define SQE_OFS_SEGMAX 8'h04
`define SQE_OFS_XFER 8'h08
`define SQE_OFS_CMDHINT 8'h0C
`define SQE_OFS_EVTSZ 8'h10
`define SQE_OFS_SENSE 8'h14
`define SQE_OFS_CDB 8'h18
`define SQE_OFS_CHAN 8'h1C
`define SQE_OFS_TGT 8'h20
`define SQE_OFS_UNIT 8'h24
`define SQE_OFS_SUBSYS 8'h28
`define SQE_OFS_FEAT_OFF 8'h2C
`define SQE_OFS_FEAT_DRV 8'h30
`define SQE_OFS_CTRL 8'h34
`define SQE_OFS_STAT 8'h38

// ****************************************
// Configuration values and reset values
// ****************************************
`define SQE_NUM_RQ 32'h0000_0004
`define SQE_SEG_MAX 32'h0000_0080
`define SQE_XFER_HINT 32'h0000_0400
`define SQE_CMD_HINT 32'h0000_0080
`define SQE_EVT_BASE 32'h0000_0010
`define SQE_EVT_LIVE 32'h0000_0018
`define SQE_SENSE_RST 32'h0000_0060
`define SQE_CDB_RST 32'h0000_0020
`define SQE_MAX_CHAN 16'h0000
`define SQE_MAX_TGT 16'h00FF
`define SQE_MAX_UNIT 32'h0000_3FFF

// ****************************************
// Feature bits, queues, LUN layout
// ****************************************
`define SQE_F_INOUT 0
`define SQE_F_LIVE 1
`define SQE_FEAT_OFFER 32'h0000_0003
`define SQE_CTRL_RESET 0
`define SQE_Q_REQ0 8'h02
`define SQE_LUN_FMT 8'h01

// ****************************************
// Response codes and bus answers
// ****************************************
`define SQE_RESP_OK 8'h00
`define SQE_RESP_OVERRUN 8'h01
`define SQE_RESP_CANCELLED_BY_ABORT 8'h02
`define SQE_RESP_BAD_TARGET 8'h03
`define SQE_RESP_RESET 8'h04
`define SQE_RESP_FAILURE 8'h09
`define SQE_AXI_OKAY 2'b00
`define SQE_AXI_SLVERR 2'b10

`endif

/* File: logic/sqe_req_check.v */
// Admission check of one command request before it is executed
`timescale 1ns/1ps
`include "sqe_defs.vh"

module sqe_req_check (
   // Request fields
   input wire [7:0] queue,
   input wire [63:0] lun,
   input wire [31:0] out_len,
   input wire [31:0] in_len,
   input wire [15:0] out_segs,
   input wire [15:0] in_segs,
   // Configuration
   input wire inout_ok,
   // Verdict
   output reg bad,
   output reg [7:0] code
);

   wire [31:0] q_end = {24'h00_0000, `SQE_Q_REQ0} + `SQE_NUM_RQ;
   wire bidir = (out_len != 32'h0000_0000) && (in_len != 32'h0000_0000);
   wire lun_ok = (lun[63:56] == `SQE_LUN_FMT) &&
      (lun[31:0] == 32'h0000_0000);

   always @* begin
      bad = 1'b1;
      code = `SQE_RESP_FAILURE;
      if (queue < `SQE_Q_REQ0 || {24'h00_0000, queue} >= q_end) begin
         code = `SQE_RESP_FAILURE;
      end else if (bidir && !inout_ok) begin
         code = `SQE_RESP_FAILURE;
      end else if ({16'h0000, out_segs} > `SQE_SEG_MAX ||
            {16'h0000, in_segs} > `SQE_SEG_MAX) begin
         code = `SQE_RESP_FAILURE;
      end else if (!lun_ok ||
            {8'h00, lun[55:48]} > `SQE_MAX_TGT) begin
         code = `SQE_RESP_BAD_TARGET;
      end else begin
         bad = 1'b0;
         code = `SQE_RESP_OK;
      end
   end

endmodule

/* File: logic/sqe_engine.v */
// SCSI host request queue engine with AXI4-Lite configuration space
`timescale 1ns/1ps
`include "sqe_defs.vh"

module sqe_engine #(
   // Arbitrary value standing for the host type code
   parameter [31:0] SUBSYS_ID = 32'h0000_00A5
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // AXI4-Lite write channels
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read channels
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Request intake
   input wire req_valid,
   output reg req_ready,
   input wire [7:0] req_queue,
   input wire [63:0] req_lun,
   input wire [63:0] req_tag,
   input wire [31:0] req_out_len,
   input wire [31:0] req_in_len,
   input wire [15:0] req_out_segs,
   input wire [15:0] req_in_segs,
   // Execution towards the logical units
   output reg exec_valid,
   input wire exec_ready,
   output reg [63:0] exec_tag,
   output reg [7:0] exec_target,
   output reg [13:0] exec_unit,
   output reg [31:0] exec_cdb_len,
   output reg [31:0] exec_out_len,
   output reg [31:0] exec_in_len,
   input wire exec_done,
   input wire [7:0] exec_status,
   input wire [7:0] exec_resp,
   input wire [31:0] exec_need,
   input wire [31:0] exec_out_done,
   input wire [31:0] exec_in_done,
   input wire [31:0] exec_sense_cnt,
   // Completion
   output reg cpl_valid,
   input wire cpl_ready,
   output reg [7:0] cpl_queue,
   output reg [63:0] cpl_tag,
   output reg [7:0] cpl_status,
   output reg [7:0] cpl_resp,
   output reg [31:0] cpl_residual,
   output reg [31:0] cpl_sense_len,
   // Feature state
   output reg live_attach_en
);

   // ****************************************
   // State and storage
   // ****************************************
   localparam ST_IDLE = 2'd0;
   localparam ST_ISSUE = 2'd1;
   localparam ST_WAIT = 2'd2;
   localparam ST_CPL = 2'd3;

   reg [1:0] state;
   reg [31:0] sense_limit;
   reg [31:0] cdb_limit;
   reg [31:0] drv_feat;
   reg [15:0] cpl_count;
   reg rst_seen;
   reg [31:0] tot_len;
   reg aw_have;
   reg w_have;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;

   wire [31:0] neg_feat = drv_feat & `SQE_FEAT_OFFER;
   wire inout_ok = neg_feat[`SQE_F_INOUT];
   wire chk_bad;
   wire [7:0] chk_code;
   wire [31:0] wmask;
   wire wr_go = aw_have && w_have && !s_axi_bvalid;
   wire [5:0] wr_word = aw_addr[7:2];
   wire dev_reset = wr_go && aw_addr == `SQE_OFS_CTRL &&
      w_strb[0] && w_data[`SQE_CTRL_RESET];
   wire [31:0] evt_size = neg_feat[`SQE_F_LIVE] ?
      `SQE_EVT_LIVE : `SQE_EVT_BASE;
   wire [31:0] xfer = exec_out_done + exec_in_done;
   reg [31:0] next_rdata;
   reg next_rerr;
   reg next_werr;

   // ****************************************
   // Byte lane mask
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
         assign wmask[gi*8 +: 8] = {8{w_strb[gi]}};
      end
   endgenerate

   // ****************************************
   // Admission check
   // ****************************************
   sqe_req_check u_check (
      .queue(req_queue),
      .lun(req_lun),
      .out_len(req_out_len),
      .in_len(req_in_len),
      .out_segs(req_out_segs),
      .in_segs(req_in_segs),
      .inout_ok(inout_ok),
      .bad(chk_bad),
      .code(chk_code)
   );

   // ****************************************
   // Register read decode
   // ****************************************
   always @* begin
      next_rerr = 1'b0;
      case (s_axi_araddr)
         `SQE_OFS_QCNT: next_rdata = `SQE_NUM_RQ;
         `SQE_OFS_SEGMAX: next_rdata = `SQE_SEG_MAX;
         `SQE_OFS_XFER: next_rdata = `SQE_XFER_HINT;
         `SQE_OFS_CMDHINT: next_rdata = `SQE_CMD_HINT;
         `SQE_OFS_EVTSZ: next_rdata = evt_size;
         `SQE_OFS_SENSE: next_rdata = sense_limit;
         `SQE_OFS_CDB: next_rdata = cdb_limit;
         `SQE_OFS_CHAN: next_rdata = {16'h0000, `SQE_MAX_CHAN};
         `SQE_OFS_TGT: next_rdata = {16'h0000, `SQE_MAX_TGT};
         `SQE_OFS_UNIT: next_rdata = `SQE_MAX_UNIT;
         `SQE_OFS_SUBSYS: next_rdata = SUBSYS_ID;
         `SQE_OFS_FEAT_OFF: next_rdata = `SQE_FEAT_OFFER;
         `SQE_OFS_FEAT_DRV: next_rdata = neg_feat;
         `SQE_OFS_CTRL: next_rdata = 32'h0000_0000;
         `SQE_OFS_STAT: next_rdata = {14'h0000, state, cpl_count};
         default: begin
            next_rdata = 32'h0000_0000;
            next_rerr = 1'b1;
         end
      endcase
   end

   // Unmapped word addresses answer SLVERR; read-only ones take no effect
   always @* begin
      case (aw_addr)
         `SQE_OFS_QCNT, `SQE_OFS_SEGMAX, `SQE_OFS_XFER,
         `SQE_OFS_CMDHINT, `SQE_OFS_EVTSZ, `SQE_OFS_SENSE,
         `SQE_OFS_CDB, `SQE_OFS_CHAN, `SQE_OFS_TGT,
         `SQE_OFS_UNIT, `SQE_OFS_SUBSYS, `SQE_OFS_FEAT_OFF,
         `SQE_OFS_FEAT_DRV, `SQE_OFS_CTRL,
         `SQE_OFS_STAT: next_werr = 1'b0;
         default: next_werr = 1'b1;
      endcase
   end

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SQE_AXI_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SQE_AXI_OKAY;
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= next_werr ? `SQE_AXI_SLVERR : `SQE_AXI_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rerr ? `SQE_AXI_SLVERR : `SQE_AXI_OKAY;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ****************************************
   // Writable configuration
   // ****************************************
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sense_limit <= `SQE_SENSE_RST;
         cdb_limit <= `SQE_CDB_RST;
         drv_feat <= 32'h0000_0000;
         live_attach_en <= 1'b0;
      end else begin
         live_attach_en <= neg_feat[`SQE_F_LIVE];
         if (dev_reset) begin
            // A device reset also drops the negotiated features
            sense_limit <= `SQE_SENSE_RST;
            cdb_limit <= `SQE_CDB_RST;
            drv_feat <= 32'h0000_0000;
         end else if (wr_go) begin
            case (wr_word)
               `SQE_OFS_SENSE >> 2: sense_limit <=
                  (sense_limit & ~wmask) | (w_data & wmask);
               `SQE_OFS_CDB >> 2: cdb_limit <=
                  (cdb_limit & ~wmask) | (w_data & wmask);
               `SQE_OFS_FEAT_DRV >> 2: drv_feat <=
                  (drv_feat & ~wmask) | (w_data & wmask);
               default: drv_feat <= drv_feat;
            endcase
         end
      end
   end

   // ****************************************
   // Request sequencer
   // ****************************************
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         req_ready <= 1'b1;
         exec_valid <= 1'b0;
         exec_tag <= 64'h0000_0000_0000_0000;
         exec_target <= 8'h00;
         exec_unit <= 14'h0000;
         exec_cdb_len <= 32'h0000_0000;
         exec_out_len <= 32'h0000_0000;
         exec_in_len <= 32'h0000_0000;
         cpl_valid <= 1'b0;
         cpl_queue <= 8'h00;
         cpl_tag <= 64'h0000_0000_0000_0000;
         cpl_status <= 8'h00;
         cpl_resp <= `SQE_RESP_OK;
         cpl_residual <= 32'h0000_0000;
         cpl_sense_len <= 32'h0000_0000;
         cpl_count <= 16'h0000;
         rst_seen <= 1'b0;
         tot_len <= 32'h0000_0000;
      end else begin
         // A reset arriving mid-command cancels it at completion
         if (dev_reset && state != ST_IDLE && state != ST_CPL) begin
            rst_seen <= 1'b1;
         end
         case (state)
            ST_IDLE: begin
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  // Attribute, priority and reference are not looked at
                  cpl_queue <= req_queue;
                  cpl_tag <= req_tag;
                  tot_len <= req_out_len + req_in_len;
                  if (chk_bad) begin
                     // Refused at once: nothing moved, no sense
                     cpl_valid <= 1'b1;
                     cpl_resp <= chk_code;
                     cpl_status <= 8'h00;
                     cpl_residual <= req_out_len + req_in_len;
                     cpl_sense_len <= 32'h0000_0000;
                     state <= ST_CPL;
                  end else begin
                     exec_valid <= 1'b1;
                     exec_tag <= req_tag;
                     exec_target <= req_lun[55:48];
                     exec_unit <= req_lun[45:32];
                     exec_cdb_len <= cdb_limit;
                     exec_out_len <= req_out_len;
                     exec_in_len <= req_in_len;
                     state <= ST_ISSUE;
                  end
               end
            end
            ST_ISSUE: begin
               if (exec_ready) begin
                  exec_valid <= 1'b0;
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (exec_done) begin
                  cpl_valid <= 1'b1;
                  cpl_status <= exec_status;
                  cpl_residual <= tot_len - xfer;
                  cpl_sense_len <= (exec_sense_cnt > sense_limit) ?
                     sense_limit : exec_sense_cnt;
                  if (rst_seen || dev_reset) begin
                     cpl_resp <= `SQE_RESP_RESET;
                  end else if (exec_need > tot_len) begin
                     cpl_resp <= `SQE_RESP_OVERRUN;
                  end else begin
                     cpl_resp <= exec_resp;
                  end
                  rst_seen <= 1'b0;
                  state <= ST_CPL;
               end
            end
            ST_CPL: begin
               if (cpl_ready) begin
                  cpl_valid <= 1'b0;
                  cpl_count <= cpl_count + 16'h0001;
                  req_ready <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
               req_ready <= 1'b1;
            end
         endcase
      end
   end

endmodule

/* File: tb/sqe_lu_model.sv */
// Logical unit back end answering the engine's execution requests
`timescale 1ns/1ps
module sqe_lu_model (
   // Clock, reset and knobs
   input wire clk_sys,
   input wire rst_n,
   input wire [7:0] m_delay, m_resp, m_stat,
   input wire m_short,
   input wire [31:0] m_extra, m_sense,
   // Execution side
   input wire exec_valid,
   output reg exec_ready,
   output reg exec_done,
   input wire [31:0] exec_out_len, exec_in_len,
   output wire [7:0] exec_status, exec_resp,
   output wire [31:0] exec_need, exec_out_done, exec_in_done, exec_sense_cnt
);
   reg [7:0] cnt;
   reg busy;
   // Results are inverted outside the done cycle so stale sampling shows
   assign exec_resp = m_resp ^ {8{!exec_done}};
   assign exec_status = m_stat ^ {8{!exec_done}};
   assign exec_need = (exec_out_len + exec_in_len + m_extra)
      ^ {32{!exec_done}};
   assign exec_out_done = (m_short ? exec_out_len >> 1 : exec_out_len)
      ^ {32{!exec_done}};
   assign exec_in_done = (m_short ? 32'h0 : exec_in_len)
      ^ {32{!exec_done}};
   assign exec_sense_cnt = m_sense ^ {32{!exec_done}};
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         exec_ready <= 1'b0;
         exec_done <= 1'b0;
         busy <= 1'b0;
         cnt <= 8'h00;
      end else begin
         exec_ready <= 1'b0;
         exec_done <= 1'b0;
         if (busy || (exec_valid && !exec_ready)) begin
            cnt <= cnt + 8'h01;
            if (cnt == m_delay) begin
               cnt <= 8'h00;
               exec_ready <= !busy;
               exec_done <= busy;
               busy <= !busy;
            end
         end
      end
   end
endmodule

/* File: tb/sqe_engine_props.sv */
// Concurrent checks on the request engine ports
`timescale 1ns/1ps
module sqe_props (
   // Clock, reset and bus handshakes
   input wire clk_sys,
   input wire rst_n,
   input wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   // Request intake
   input wire req_valid, req_ready,
   input wire [7:0] req_queue,
   input wire [63:0] req_lun, req_tag,
   input wire [31:0] req_out_len, req_in_len,
   input wire [15:0] req_out_segs, req_in_segs,
   // Execution and completion
   input wire exec_valid, exec_done, cpl_valid, cpl_ready,
   input wire [7:0] exec_target, cpl_queue, cpl_resp,
   input wire [13:0] exec_unit,
   input wire [31:0] exec_out_len, exec_in_len, exec_need, exec_out_done,
   input wire [31:0] exec_in_done, cpl_residual,
   input wire [63:0] cpl_tag
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   reg [7:0] q_l;
   reg [63:0] lun_l, tag_l;
   reg [31:0] res_l;
   wire hs = req_valid && req_ready;
   wire q_ok = req_queue >= 8'h02 && req_queue <= 8'h05;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q_l <= 8'h00;
         lun_l <= 64'h0;
         tag_l <= 64'h0;
         res_l <= 32'h0;
      end else if (hs) begin
         q_l <= req_queue;
         lun_l <= req_lun;
         tag_l <= req_tag;
         res_l <= req_out_len + req_in_len;
      end else if (exec_done) begin
         res_l <= exec_out_len + exec_in_len - exec_out_done - exec_in_done;
      end
   end
   AST_B_AFTER_WRITE: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid)
      else $error("write answer missing");
   AST_R_AFTER_READ: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer missing");
   AST_BAD_QUEUE: assert property (hs && !q_ok
      |=> cpl_valid && cpl_resp == 8'h09) else $error("bad queue taken");
   AST_BAD_LUN: assert property (hs && q_ok && req_lun[63:56] != 8'h01 &&
      req_out_segs <= 16'h0080 && req_in_segs <= 16'h0080 &&
      (req_out_len == 32'h0 || req_in_len == 32'h0)
      |=> cpl_valid && cpl_resp == 8'h03) else $error("bad unit taken");
   AST_EXEC_ADDR: assert property ($rose(exec_valid) |->
      exec_target == lun_l[55:48] && exec_unit == lun_l[45:32])
      else $error("target or unit wrong");
   AST_ECHO: assert property ($rose(cpl_valid) |->
      cpl_queue == q_l && cpl_tag == tag_l) else $error("queue echo wrong");
   AST_RESIDUAL: assert property ($rose(cpl_valid) |->
      cpl_residual == res_l) else $error("residual wrong");
   AST_OVERRUN: assert property (exec_done &&
      exec_need > exec_out_len + exec_in_len
      |=> cpl_valid && cpl_resp inside {8'h01, 8'h04})
      else $error("overrun missed");
   AST_CPL_HOLD: assert property (cpl_valid && !cpl_ready |=> cpl_valid &&
      $stable(cpl_resp) && $stable(cpl_residual)) else $error("cpl dropped");
   AST_ONE_AT_A_TIME: assert property (hs |=> !req_ready[*2])
      else $error("second request taken");
   cover property (hs && q_ok ##1 exec_valid);
   cover property (cpl_valid && cpl_resp == 8'h09);
   cover property (cpl_valid && cpl_resp == 8'h01);
   cover property (s_axi_bvalid);
endmodule
bind sqe_engine sqe_props u_props (.*);

/* File: tb/tb_top.sv */
// Self-checking bench for the request engine
`timescale 1ns/1ps
`include "sqe_defs.vh"
module tb_top;
   logic clk_sys, rst_n, feat, m_short;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, req_valid, cpl_ready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, req_queue, m_delay, m_resp, m_stat;
   logic [31:0] s_axi_wdata, req_out_len, req_in_len, m_extra, m_sense;
   logic [31:0] sense_cur, cdb_cur;
   logic [3:0] s_axi_wstrb;
   logic [63:0] req_lun, req_tag;
   logic [15:0] req_out_segs, req_in_segs, rnd, r1;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, req_ready, exec_valid, exec_ready, exec_done;
   wire cpl_valid, live_attach_en;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata, exec_cdb_len, exec_out_len, exec_in_len;
   wire [31:0] exec_need, exec_out_done, exec_in_done, exec_sense_cnt;
   wire [31:0] cpl_residual, cpl_sense_len;
   wire [7:0] exec_target, exec_status, exec_resp, cpl_queue, cpl_status;
   wire [7:0] cpl_resp;
   wire [13:0] exec_unit;
   wire [63:0] exec_tag, cpl_tag;
   integer n_fail, n_tests, i;
   logic [7:0] codes [0:7] = '{8'h00, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07,
      8'h08, 8'h09};
   sqe_engine u_dut (.*);
   sqe_lu_model u_lu (.*);
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   function [15:0] lfsr(input [15:0] x);
      lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function [63:0] mk_lun(input [7:0] t, input [13:0] u);
      mk_lun = {`SQE_LUN_FMT, t, 2'b00, u, 32'h0000_0000};
   endfunction
   task chk(input [63:0] g, input [63:0] e);
      begin
         n_tests = n_tests + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", n_tests, n_fail);
         if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
         end else begin
            $display("Finished with errors");
         end
         $finish;
      end
   endtask
   // ****************
   // Bus and request tasks
   // ****************
   task axi_wr(input [7:0] a, input [31:0] d, input [1:0] e);
      integer k;
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         for (k = 0; k < 40; k = k + 1) begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
               chk(s_axi_bresp, e);
               k = 50;
            end
         end
         if (k < 50) chk(k, 50);
      end
   endtask
   task axi_rd(input [7:0] a, input [31:0] d, input [1:0] e);
      integer k;
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         for (k = 0; k < 40; k = k + 1) begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
               chk({s_axi_rdata, s_axi_rresp}, {d, e});
               k = 50;
            end
         end
         if (k < 50) chk(k, 50);
      end
   endtask
   task issue(input [7:0] q, input [63:0] lun, input [31:0] ol, il,
      input [15:0] os, is, input [7:0] rc, input sh, input [31:0] ex, sn,
      input rs);
      logic [7:0] er, es;
      logic [31:0] eres, esn, ecdb;
      logic [63:0] tg;
      integer k;
      begin
         er = 8'h00;
         if (q < 8'h02 || q > 8'h05) er = `SQE_RESP_FAILURE;
         else if (ol != 0 && il != 0 && !feat) er = `SQE_RESP_FAILURE;
         else if (os > 16'h0080 || is > 16'h0080) er = `SQE_RESP_FAILURE;
         else if (lun[63:56] != 8'h01 || lun[31:0] != 0) er = 8'h03;
         eres = ol + il;
         esn = 32'h0;
         es = 8'h00;
         if (er == 8'h00) begin
            er = rs ? `SQE_RESP_RESET : (ex != 0 ? `SQE_RESP_OVERRUN : rc);
            eres = sh ? ol - (ol >> 1) + il : 32'h0;
            esn = sn < sense_cur ? sn : sense_cur;
            es = {rc[3:0], 4'h1};
         end
         ecdb = cdb_cur;
         rnd = lfsr(rnd);
         tg = {rnd, ~rnd, rnd ^ 16'h5A5A, rnd};
         {m_resp, m_stat, m_short} <= {rc, rc[3:0], 4'h1, sh};
         {m_extra, m_sense} <= {ex, sn};
         {req_queue, req_lun, req_tag} <= {q, lun, tg};
         {req_out_len, req_in_len, req_out_segs, req_in_segs} <= {ol, il, os, is};
         req_valid <= 1'b1;
         for (k = 0; k < 400; k = k + 1) begin
            @(posedge clk_sys);
            if (req_ready) req_valid <= 1'b0;
            if (exec_valid && exec_ready)
               chk({exec_cdb_len, tg[31:0]}, {ecdb, exec_tag[31:0]});
            if (cpl_valid) begin
               chk({cpl_resp, cpl_status}, {er, es});
               chk({cpl_residual, cpl_sense_len}, {eres, esn});
               chk({cpl_queue, cpl_tag[55:0]}, {q, tg[55:0]});
               cpl_ready <= 1'b1;
               k = 500;
            end
         end
         if (k < 500) chk(k, 500);
         @(posedge clk_sys);
         cpl_ready <= 1'b0;
      end
   endtask
   // ****************
   // Main sequence
   // ****************
   initial begin
      {rst_n, feat, m_short, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h0;
      {s_axi_arvalid, s_axi_rready, req_valid, cpl_ready} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, m_delay} = 56'h0;
      {req_queue, req_lun, req_tag, req_out_len, req_in_len} = 200'h0;
      {req_out_segs, req_in_segs, m_resp, m_stat, m_extra, m_sense} = 112'h0;
      s_axi_wstrb = 4'hF;
      {n_fail, n_tests, rnd} = {32'h0, 32'h0, 16'h4AB9};
      {sense_cur, cdb_cur} = {`SQE_SENSE_RST, `SQE_CDB_RST};
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      axi_rd(`SQE_OFS_QCNT, `SQE_NUM_RQ, 2'b00);
      axi_rd(`SQE_OFS_CMDHINT, `SQE_CMD_HINT, 2'b00);
      axi_rd(`SQE_OFS_SEGMAX, `SQE_SEG_MAX, 2'b00);
      axi_rd(`SQE_OFS_SUBSYS, 32'h0000_00A5, 2'b00);
      axi_rd(`SQE_OFS_FEAT_OFF, `SQE_FEAT_OFFER, 2'b00);
      axi_rd(`SQE_OFS_EVTSZ, `SQE_EVT_BASE, 2'b00);
      axi_rd(`SQE_OFS_SENSE, 32'h0000_0060, 2'b00);
      axi_rd(`SQE_OFS_CDB, 32'h0000_0020, 2'b00);
      axi_rd(8'h3C, 32'h0, `SQE_AXI_SLVERR);
      axi_wr(`SQE_OFS_QCNT, 32'h0000_00FF, `SQE_AXI_OKAY);
      axi_rd(`SQE_OFS_QCNT, `SQE_NUM_RQ, 2'b00);
      axi_wr(`SQE_OFS_SENSE, 32'h0000_0020, `SQE_AXI_OKAY);
      axi_wr(`SQE_OFS_CDB, 32'h0000_0010, `SQE_AXI_OKAY);
      {sense_cur, cdb_cur} = {32'h0000_0020, 32'h0000_0010};
      axi_rd(`SQE_OFS_SENSE, sense_cur, 2'b00);
      for (i = 0; i < 8; i = i + 1) begin
         issue(8'h00 + i[7:0] * 8'h03, mk_lun(8'h05, 14'h0002), 32'h8, 32'h0,
            16'h1, 16'h0, 8'h00, 1'b0, 32'h0, 32'h30, 1'b0);
      end
      issue(8'h02, mk_lun(8'h01, 14'h0), 32'h8, 32'h8, 16'h1, 16'h1, 8'h00,
         1'b0, 32'h0, 32'h4, 1'b0);
      issue(8'h03, mk_lun(8'h01, 14'h0), 32'h8, 32'h0, 16'h0081, 16'h0,
         8'h00, 1'b0, 32'h0, 32'h4, 1'b0);
      issue(8'h04, {8'h02, 56'h0}, 32'h8, 32'h0, 16'h1, 16'h0, 8'h00, 1'b0,
         32'h0, 32'h4, 1'b0);
      issue(8'h04, mk_lun(8'h01, 14'h0) | 64'h1, 32'h8, 32'h0, 16'h1, 16'h0,
         8'h00, 1'b0, 32'h0, 32'h4, 1'b0);
      axi_wr(`SQE_OFS_FEAT_DRV, 32'h0000_0003, `SQE_AXI_OKAY);
      feat = 1'b1;
      @(posedge clk_sys);
      chk(live_attach_en, 1'b1);
      axi_rd(`SQE_OFS_EVTSZ, `SQE_EVT_LIVE, 2'b00);
      for (i = 0; i < 24; i = i + 1) begin
         rnd = lfsr(rnd);
         r1 = rnd;
         rnd = lfsr(rnd);
         m_delay <= {6'h00, rnd[1:0]};
         issue(8'h02 + {6'h00, r1[1:0]}, mk_lun(r1[9:2], rnd[15:2]),
            {24'h0, r1[15:8]}, r1[3] ? {24'h0, rnd[15:8]} : 32'h0,
            16'h0001 + {9'h0, rnd[6:0]}, 16'h0080, codes[i % 8], r1[4],
            r1[5] ? {29'h0, rnd[12:10]} + 32'h1 : 32'h0,
            {26'h0, r1[15:10]}, 1'b0);
      end
      m_delay <= 8'h08;
      fork
         issue(8'h05, mk_lun(8'hFF, 14'h3FFF), 32'h10, 32'h0, 16'h1, 16'h0,
            8'h00, 1'b0, 32'h0, 32'h10, 1'b1);
         begin
            repeat (3) @(posedge clk_sys);
            axi_wr(`SQE_OFS_CTRL, 32'h0000_0001, `SQE_AXI_OKAY);
         end
      join
      {sense_cur, cdb_cur, feat} = {`SQE_SENSE_RST, `SQE_CDB_RST, 1'b0};
      axi_rd(`SQE_OFS_SENSE, 32'h0000_0060, 2'b00);
      axi_rd(`SQE_OFS_CDB, 32'h0000_0020, 2'b00);
      axi_rd(`SQE_OFS_EVTSZ, `SQE_EVT_BASE, 2'b00);
      chk(live_attach_en, 1'b0);
      m_delay <= 8'h00;
      issue(8'h02, mk_lun(8'h01, 14'h0), 32'h4, 32'h4, 16'h1, 16'h1, 8'h00,
         1'b0, 32'h0, 32'h4, 1'b0);
      test_done;
   end
   initial begin
      repeat (30000) @(posedge clk_sys);
      n_fail = n_fail + 1;
      test_done;
   end
endmodule
